//--- design/ifsb_pkg.sv
// constants, field positions and types of the interrupt request flag bank.
// assumes one system clock at 100 MHz and an APB slave with 32-bit data.
//
// Contract
// - hardware sets each implemented flag bit when its source requests.
// - software can read and write every implemented flag bit.
// - all flag bits of both registers are zero after power-on reset.
// - low bits 14, 10-9, 4 and high bits 10-7, 5 always read as zero.
// - low register bit 15 is memory write done, bit 13 conversion done.
// - low register bit 12 is serial A transmit, bit 11 serial A receive.
// - capture timers: B bit 8, A bit 7 low; D bit 12, C bit 11 high.
// - capture events D, C, B, A at low bits 6, 5, 2, 1; E at high bit 6.
// - low register bit 3 is the first timer, bit 0 external pin A.
// - high register bit 15 is serial B transmit, bit 14 serial B receive.
// - high register bit 13 is external pin C, bit 4 external pin B.
// - high register bit 3 is pin change, bit 2 comparator.
// - high register bit 1 is port A collision, bit 0 port A event.
// - a set flag forwards its request only while its enable bit is 1.
// - polarity 1 selects the falling pin edge, 0 the rising edge.

package ifsb_pkg;

  localparam int IFSB_WORD_W = 16;
  localparam int IFSB_ADDR_W = 12;
  localparam int IFSB_EXT_N  = 3;

  typedef logic [IFSB_WORD_W-1:0] ifsb_word_t;
  typedef logic [IFSB_ADDR_W-1:0] ifsb_addr_t;

  // register byte offsets
  localparam ifsb_addr_t OFS_FLAGS_LOW   = 12'h000;
  localparam ifsb_addr_t OFS_FLAGS_HIGH  = 12'h004;
  localparam ifsb_addr_t OFS_ENABLE_LOW  = 12'h008;
  localparam ifsb_addr_t OFS_ENABLE_HIGH = 12'h00C;
  localparam ifsb_addr_t OFS_POLARITY    = 12'h010;
  localparam ifsb_addr_t OFS_PEND_LOW    = 12'h014;
  localparam ifsb_addr_t OFS_PEND_HIGH   = 12'h018;

  // implemented bit masks and reset values
  localparam ifsb_word_t MASK_LOW        = 16'hB9EF;
  localparam ifsb_word_t MASK_HIGH       = 16'hF85F;
  localparam ifsb_word_t RST_FLAGS       = 16'h0000;
  localparam ifsb_word_t RST_ENABLE      = 16'h0000;
  localparam logic [IFSB_EXT_N-1:0] RST_POLARITY = 3'h0;

  // low register positions
  localparam int POS_MEM_DONE    = 15;
  localparam int POS_CONV_DONE   = 13;
  localparam int POS_SER_A_TX    = 12;
  localparam int POS_SER_A_RX    = 11;
  localparam int POS_TIMER_B     = 8;
  localparam int POS_TIMER_A     = 7;
  localparam int POS_EVENT_D     = 6;
  localparam int POS_EVENT_C     = 5;
  localparam int POS_FIRST_TIMER = 3;
  localparam int POS_EVENT_B     = 2;
  localparam int POS_EVENT_A     = 1;
  localparam int POS_EXT_A       = 0;

  // high register positions
  localparam int POS_SER_B_TX    = 15;
  localparam int POS_SER_B_RX    = 14;
  localparam int POS_EXT_C       = 13;
  localparam int POS_TIMER_D     = 12;
  localparam int POS_TIMER_C     = 11;
  localparam int POS_EVENT_E     = 6;
  localparam int POS_EXT_B       = 4;
  localparam int POS_PIN_CHANGE  = 3;
  localparam int POS_COMPARATOR  = 2;
  localparam int POS_COLLISION   = 1;
  localparam int POS_PORT_EVENT  = 0;

  // polarity register positions, one per external pin
  localparam int POL_EXT_A       = 0;
  localparam int POL_EXT_B       = 1;
  localparam int POL_EXT_C       = 2;

endpackage : ifsb_pkg

//--- design/ifsb_edge_if.sv
// pin, polarity and edge event bundle between the bank and its detector.
// assumes pins already synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none

interface ifsb_edge_if #(
  parameter int N = 3
);
  logic [N-1:0] pin;
  logic [N-1:0] falling_sel;
  logic [N-1:0] edge_evt;

  modport bank (
    output pin,
    output falling_sel,
    input  edge_evt
  );

  modport det (
    input  pin,
    input  falling_sel,
    output edge_evt
  );
endinterface : ifsb_edge_if

`default_nettype wire

//--- design/ifsb_edge_detect.sv
// edge detector for the external interrupt pins.
// assumes pins synchronous to clk_sys; one-cycle event per selected edge.
`timescale 1ns/1ps
`default_nettype none

module ifsb_edge_detect #(
  parameter int N = 3
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  ifsb_edge_if.det  edges
);

  logic [N-1:0] prev_r;
  logic         armed_r;

  // first cycle after reset only samples, so a pin that is already
  // high or low at release does not fake an edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prev_r <= '0;
    end else begin
      prev_r <= edges.pin;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_edge
      assign edges.edge_evt[g] = armed_r & (edges.falling_sel[g]
                                 ? (prev_r[g] & ~edges.pin[g])
                                 : (~prev_r[g] & edges.pin[g]));
    end
  endgenerate

endmodule : ifsb_edge_detect

`default_nettype wire

//--- design/ifsb_flag_bank.sv
// interrupt request flag bank: two 16-bit flag words, enables, pin
// polarity and pending view, reached over an APB slave.
// assumes peripheral requests are synchronous one-cycle or level pulses;
// a level held high keeps its flag set against software clears.
`timescale 1ns/1ps
`default_nettype none

module ifsb_flag_bank (
  input  wire logic                      clk_sys,
  input  wire logic                      resetn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire ifsb_pkg::ifsb_addr_t      paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // peripheral request sources
  input  wire logic                      memory_write_done_req,
  input  wire logic                      conversion_done_req,
  input  wire logic                      serial_a_tx_req,
  input  wire logic                      serial_a_rx_req,
  input  wire logic                      serial_b_tx_req,
  input  wire logic                      serial_b_rx_req,
  input  wire logic                      capcmp_timer_a_req,
  input  wire logic                      capcmp_timer_b_req,
  input  wire logic                      capcmp_timer_c_req,
  input  wire logic                      capcmp_timer_d_req,
  input  wire logic                      capcmp_event_a_req,
  input  wire logic                      capcmp_event_b_req,
  input  wire logic                      capcmp_event_c_req,
  input  wire logic                      capcmp_event_d_req,
  input  wire logic                      capcmp_event_e_req,
  input  wire logic                      first_timer_req,
  input  wire logic                      pin_change_req,
  input  wire logic                      comparator_req,
  input  wire logic                      port_a_collision_req,
  input  wire logic                      port_a_event_req,
  // external interrupt pins
  input  wire logic                      ext_pin_a,
  input  wire logic                      ext_pin_b,
  input  wire logic                      ext_pin_c,
  // enabled requests towards the priority logic
  output ifsb_pkg::ifsb_word_t           request_pending_low,
  output ifsb_pkg::ifsb_word_t           request_pending_high,
  output logic                           request_any
);

  import ifsb_pkg::*;

  ifsb_word_t                request_flags_low_r;
  ifsb_word_t                request_flags_high_r;
  ifsb_word_t                request_flags_low_nxt;
  ifsb_word_t                request_flags_high_nxt;
  ifsb_word_t                request_enable_low_r;
  ifsb_word_t                request_enable_high_r;
  logic [IFSB_EXT_N-1:0]     ext_pin_polarity_r;
  logic [31:0]               prdata_r;
  logic [31:0]               prdata_nxt;
  ifsb_word_t                hw_set_low;
  ifsb_word_t                hw_set_high;
  ifsb_word_t                lane_mask;
  ifsb_word_t                wdata16;
  logic                      setup_phase;
  logic                      access_phase;
  logic                      addr_hit;
  logic                      wr_flags_low;
  logic                      wr_flags_high;
  logic                      wr_enable_low;
  logic                      wr_enable_high;
  logic                      wr_polarity;

  // ---------------------------------------------------------------
  // external pin edge detection
  // ---------------------------------------------------------------
  ifsb_edge_if #(.N(IFSB_EXT_N)) edge_bus ();

  assign edge_bus.pin[POL_EXT_A]         = ext_pin_a;
  assign edge_bus.pin[POL_EXT_B]         = ext_pin_b;
  assign edge_bus.pin[POL_EXT_C]         = ext_pin_c;
  assign edge_bus.falling_sel            = ext_pin_polarity_r;

  ifsb_edge_detect #(
    .N       (IFSB_EXT_N)
  ) u_edge (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .edges   (edge_bus.det)
  );

  // ---------------------------------------------------------------
  // hardware set vectors, one line per source position
  // ---------------------------------------------------------------
  always_comb begin
    hw_set_low                  = '0;
    hw_set_low[POS_MEM_DONE]    = memory_write_done_req;
    hw_set_low[POS_CONV_DONE]   = conversion_done_req;
    hw_set_low[POS_SER_A_TX]    = serial_a_tx_req;
    hw_set_low[POS_SER_A_RX]    = serial_a_rx_req;
    hw_set_low[POS_TIMER_B]     = capcmp_timer_b_req;
    hw_set_low[POS_TIMER_A]     = capcmp_timer_a_req;
    hw_set_low[POS_EVENT_D]     = capcmp_event_d_req;
    hw_set_low[POS_EVENT_C]     = capcmp_event_c_req;
    hw_set_low[POS_EVENT_B]     = capcmp_event_b_req;
    hw_set_low[POS_EVENT_A]     = capcmp_event_a_req;
    hw_set_low[POS_FIRST_TIMER] = first_timer_req;
    hw_set_low[POS_EXT_A]       = edge_bus.edge_evt[POL_EXT_A];
  end

  always_comb begin
    hw_set_high                 = '0;
    hw_set_high[POS_SER_B_TX]   = serial_b_tx_req;
    hw_set_high[POS_SER_B_RX]   = serial_b_rx_req;
    hw_set_high[POS_EXT_C]      = edge_bus.edge_evt[POL_EXT_C];
    hw_set_high[POS_EXT_B]      = edge_bus.edge_evt[POL_EXT_B];
    hw_set_high[POS_TIMER_D]    = capcmp_timer_d_req;
    hw_set_high[POS_TIMER_C]    = capcmp_timer_c_req;
    hw_set_high[POS_EVENT_E]    = capcmp_event_e_req;
    hw_set_high[POS_PIN_CHANGE] = pin_change_req;
    hw_set_high[POS_COMPARATOR] = comparator_req;
    hw_set_high[POS_COLLISION]  = port_a_collision_req;
    hw_set_high[POS_PORT_EVENT] = port_a_event_req;
  end

  // ---------------------------------------------------------------
  // apb decode; zero wait states, writes land at the access edge
  // ---------------------------------------------------------------
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign pready       = 1'b1;

  always_comb begin
    case (paddr)
      OFS_FLAGS_LOW,
      OFS_FLAGS_HIGH,
      OFS_ENABLE_LOW,
      OFS_ENABLE_HIGH,
      OFS_POLARITY,
      OFS_PEND_LOW,
      OFS_PEND_HIGH: addr_hit = 1'b1;
      default:       addr_hit = 1'b0;
    endcase
  end

  // pending words are read-only, so writes to them are an error too
  assign pslverr = access_phase & (~addr_hit
                   | (pwrite & (paddr == OFS_PEND_LOW
                              | paddr == OFS_PEND_HIGH)));

  assign wdata16 = pwdata[IFSB_WORD_W-1:0];

  genvar b;
  generate
    for (b = 0; b < IFSB_WORD_W; b++) begin : g_lane
      assign lane_mask[b] = pstrb[b / 8];
    end
  endgenerate

  assign wr_flags_low   = access_phase & pwrite & (paddr == OFS_FLAGS_LOW);
  assign wr_flags_high  = access_phase & pwrite & (paddr == OFS_FLAGS_HIGH);
  assign wr_enable_low  = access_phase & pwrite & (paddr == OFS_ENABLE_LOW);
  assign wr_enable_high = access_phase & pwrite & (paddr == OFS_ENABLE_HIGH);
  assign wr_polarity    = access_phase & pwrite & (paddr == OFS_POLARITY);

  // ---------------------------------------------------------------
  // flag bits: hardware set has priority over a software write, so a
  // request landing in the clearing cycle survives
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < IFSB_WORD_W; i++) begin : g_flag
      if (MASK_LOW[i]) begin : g_low
        assign request_flags_low_nxt[i] = hw_set_low[i]
                                        | (wr_flags_low && lane_mask[i]
                                           ? wdata16[i]
                                           : request_flags_low_r[i]);
      end else begin : g_low_none
        assign request_flags_low_nxt[i] = 1'b0;
      end

      if (MASK_HIGH[i]) begin : g_high
        assign request_flags_high_nxt[i] = hw_set_high[i]
                                         | (wr_flags_high && lane_mask[i]
                                            ? wdata16[i]
                                            : request_flags_high_r[i]);
      end else begin : g_high_none
        assign request_flags_high_nxt[i] = 1'b0;
      end
    end
  endgenerate

  // unimplemented positions are tied low in the next value, so the
  // whole word can live in one register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      request_flags_low_r <= RST_FLAGS;
    end else begin
      request_flags_low_r <= request_flags_low_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      request_flags_high_r <= RST_FLAGS;
    end else begin
      request_flags_high_r <= request_flags_high_nxt;
    end
  end

  // ---------------------------------------------------------------
  // enable bits; unimplemented positions stay zero through the masks
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      request_enable_low_r <= RST_ENABLE;
    end else if (wr_enable_low) begin
      request_enable_low_r <= (request_enable_low_r & ~lane_mask)
                            | (wdata16 & lane_mask & MASK_LOW);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      request_enable_high_r <= RST_ENABLE;
    end else if (wr_enable_high) begin
      request_enable_high_r <= (request_enable_high_r & ~lane_mask)
                             | (wdata16 & lane_mask & MASK_HIGH);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ext_pin_polarity_r <= RST_POLARITY;
    end else if (wr_polarity && pstrb[0]) begin
      ext_pin_polarity_r <= pwdata[IFSB_EXT_N-1:0];
    end
  end

  // ---------------------------------------------------------------
  // forwarding towards the priority logic
  // ---------------------------------------------------------------
  assign request_pending_low  = request_flags_low_r
                              & request_enable_low_r;
  assign request_pending_high = request_flags_high_r
                              & request_enable_high_r;
  assign request_any = (|request_pending_low) | (|request_pending_high);

  // ---------------------------------------------------------------
  // read data is captured in the setup cycle and held through access;
  // a flag set during that one cycle shows on the next read
  // ---------------------------------------------------------------
  always_comb begin
    prdata_nxt = '0;
    case (paddr)
      OFS_FLAGS_LOW:   prdata_nxt[IFSB_WORD_W-1:0] = request_flags_low_r;
      OFS_FLAGS_HIGH:  prdata_nxt[IFSB_WORD_W-1:0] = request_flags_high_r;
      OFS_ENABLE_LOW:  prdata_nxt[IFSB_WORD_W-1:0] = request_enable_low_r;
      OFS_ENABLE_HIGH: prdata_nxt[IFSB_WORD_W-1:0] = request_enable_high_r;
      OFS_POLARITY:    prdata_nxt[IFSB_EXT_N-1:0]  = ext_pin_polarity_r;
      OFS_PEND_LOW:    prdata_nxt[IFSB_WORD_W-1:0] = request_pending_low;
      OFS_PEND_HIGH:   prdata_nxt[IFSB_WORD_W-1:0] = request_pending_high;
      default:         prdata_nxt = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata_r <= '0;
    end else if (setup_phase && !pwrite) begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

endmodule : ifsb_flag_bank

`default_nettype wire

//--- test/ifsb_assertions.sv
// checker for the flag bank: APB answers and the pending outputs.
// assumes it is bound to ifsb_flag_bank and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ifsb_checker
  import ifsb_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 resetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire ifsb_pkg::ifsb_addr_t paddr,
  input wire logic [31:0]          prdata,
  input wire logic                 pslverr,
  input wire logic                 memory_write_done_req,
  input wire logic                 serial_b_tx_req,
  input wire ifsb_pkg::ifsb_word_t request_pending_low,
  input wire ifsb_pkg::ifsb_word_t request_pending_high,
  input wire logic                 request_any
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  a_reset_clear: assert property ($rose(resetn) |->
    request_pending_low == 16'h0000 && request_pending_high == 16'h0000)
    else $error("pending word not clear after reset");
  a_unimpl_zero: assert property (
    (request_pending_low & ~MASK_LOW) == 16'h0000 &&
    (request_pending_high & ~MASK_HIGH) == 16'h0000)
    else $error("unimplemented pending bit set");
  a_any_or_words: assert property (
    request_any == (|request_pending_low || |request_pending_high))
    else $error("request_any disagrees with pending words");
  a_pend_hold: assert property (!(psel && penable && pwrite) |=>
    ($past(request_pending_low) & ~request_pending_low) == 16'h0000)
    else $error("pending bit dropped without a write");
  a_set_wins: assert property (memory_write_done_req &&
    request_pending_low[15] && !(psel && penable && pwrite &&
    paddr == OFS_ENABLE_LOW) |=> request_pending_low[15])
    else $error("held request lost against a write");
  a_rise_cause: assert property ($rose(request_pending_high[15]) |->
    $past(serial_b_tx_req) || $past(psel && penable && pwrite))
    else $error("pending bit rose without a cause");
  a_upper_zero: assert property (psel && penable && !pwrite |->
    prdata[31:16] == 16'h0000)
    else $error("read data above bit 15 not zero");
  a_unmapped_err: assert property (psel && penable && paddr > OFS_PEND_HIGH
    |-> pslverr && (pwrite || prdata == 32'h0000_0000))
    else $error("unmapped access not refused");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("error outside the access phase");
endmodule : ifsb_checker

bind ifsb_flag_bank ifsb_checker u_ifsb_checker (
  .clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr,
  .memory_write_done_req, .serial_b_tx_req, .request_pending_low,
  .request_pending_high, .request_any
);
`default_nettype wire

//--- test/ifsb_source_model.sv
// peripheral request sources and external pins facing the flag bank.
// assumes the bench asks for requests as levels, one clk_sys at a time.
`timescale 1ns/1ps
`default_nettype none
module ifsb_source_model (
  input  wire logic [19:0] want,
  input  wire logic [2:0]  flip,
  input  wire logic        clk_sys,
  output logic      [19:0] req,
  output logic      [2:0]  pin
);
  initial req = 20'h0_0000;
  initial pin = 3'h0;
  // requests leave on a clock edge, as from a synchronous peripheral
  always @(posedge clk_sys) begin
    req <= want;
  end
  // each flip is exactly one edge on that pin
  always @(posedge clk_sys) begin
    pin <= pin ^ flip;
  end
endmodule : ifsb_source_model
`default_nettype wire

//--- test/ifsb_flag_bank_bench.sv
// self-checking bench for the interrupt request flag bank.
// assumes a zero-wait APB slave and the source model beside it.
`timescale 1ns/1ps
`default_nettype none
module ifsb_flag_bank_bench;
  import ifsb_pkg::*;
  logic        clk_sys = 1'b0;
  logic        resetn, psel, penable, pwrite, pready, pslverr;
  logic        rerr, request_any;
  ifsb_addr_t  paddr;
  logic [31:0] pwdata, prdata, rdata, exp;
  logic [3:0]  pstrb;
  ifsb_word_t  pend_lo, pend_hi;
  logic [19:0] want, req;
  logic [2:0]  flip, pin;
  int          error_cnt = 0;
  int          n_compared = 0;
  // bit of each source in {high, low}: sources 0-19, then pins a, b, c
  int pos[23] = '{15, 13, 12, 11, 8, 7, 6, 5, 3, 2, 1, 31, 30, 28, 27,
                  22, 19, 18, 17, 16, 0, 20, 29};
  always #5 clk_sys = ~clk_sys;
  ifsb_source_model u_ifsb_source_model (.clk_sys, .want, .flip, .req,
    .pin);
  ifsb_flag_bank u_ifsb_flag_bank (
    .clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr,
    .memory_write_done_req(req[0]), .conversion_done_req(req[1]),
    .serial_a_tx_req(req[2]), .serial_a_rx_req(req[3]),
    .capcmp_timer_b_req(req[4]), .capcmp_timer_a_req(req[5]),
    .capcmp_event_d_req(req[6]), .capcmp_event_c_req(req[7]),
    .first_timer_req(req[8]), .capcmp_event_b_req(req[9]),
    .capcmp_event_a_req(req[10]), .serial_b_tx_req(req[11]),
    .serial_b_rx_req(req[12]), .capcmp_timer_d_req(req[13]),
    .capcmp_timer_c_req(req[14]), .capcmp_event_e_req(req[15]),
    .pin_change_req(req[16]), .comparator_req(req[17]),
    .port_a_collision_req(req[18]), .port_a_event_req(req[19]),
    .ext_pin_a(pin[0]), .ext_pin_b(pin[1]), .ext_pin_c(pin[2]),
    .request_pending_low(pend_lo), .request_pending_high(pend_hi),
    .request_any);
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // request held until pready is seen high, released only after it
  task automatic apb(input logic wr, input ifsb_addr_t a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : apb
  task automatic wr(input ifsb_addr_t a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr
  task automatic rdchk(input string nm, input ifsb_addr_t a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 4'hF);
    chk(nm, e, rdata);
  endtask : rdchk
  task automatic clear();
    wr(OFS_FLAGS_LOW, 32'h0000_0000);
    wr(OFS_FLAGS_HIGH, 32'h0000_0000);
  endtask : clear
  task automatic pulse(input int i);
    @(posedge clk_sys);
    want <= 20'h0_0001 << i;
    @(posedge clk_sys);
    want <= 20'h0_0000;
    repeat (2) @(posedge clk_sys);
  endtask : pulse
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    want = 20'h0_0000;
    flip = 3'h0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    rdchk("flags_low", OFS_FLAGS_LOW, 32'h0000_0000);
    rdchk("flags_high", OFS_FLAGS_HIGH, 32'h0000_0000);
    rdchk("polarity", OFS_POLARITY, 32'h0000_0000);
    $display("test reset_values done");
    wr(OFS_FLAGS_LOW, 32'hFFFF_FFFF);
    wr(OFS_FLAGS_HIGH, 32'hFFFF_FFFF);
    rdchk("flags_low", OFS_FLAGS_LOW, {16'h0000, MASK_LOW});
    rdchk("flags_high", OFS_FLAGS_HIGH, {16'h0000, MASK_HIGH});
    // only byte lane 0 is written, so the upper byte keeps its ones
    apb(1'b1, OFS_FLAGS_LOW, 32'h0000_0000, 4'h1);
    rdchk("flags_low", OFS_FLAGS_LOW,
          {16'h0000, MASK_LOW & 16'hFF00});
    clear();
    rdchk("flags_high", OFS_FLAGS_HIGH, 32'h0000_0000);
    $display("test software_access done");
    wr(OFS_ENABLE_LOW, 32'h0000_FFFF);
    wr(OFS_ENABLE_HIGH, 32'h0000_FFFF);
    for (int i = 0; i < 20; i++) begin
      pulse(i);
      exp = 32'h0000_0001 << pos[i];
      rdchk("flags_low", OFS_FLAGS_LOW,
            {16'h0000, exp[15:0]});
      rdchk("pend_high", OFS_PEND_HIGH,
            {16'h0000, exp[31:16]});
      chk("pend_hi", {16'h0000, exp[31:16]}, {16'h0000, pend_hi});
      clear();
    end
    $display("test source_map done");
    for (int p = 0; p < 3; p++) begin
      for (int pol = 0; pol < 2; pol++) begin
        wr(OFS_POLARITY, pol ? 32'h0000_0007 : 32'h0000_0000);
        for (int k = 0; k < 2; k++) begin
          @(posedge clk_sys);
          flip <= 3'h1 << p;
          @(posedge clk_sys);
          flip <= 3'h0;
          repeat (3) @(posedge clk_sys);
          // first flip is a rising edge, the second a falling one
          exp = ((k == 0) == (pol == 0)) ? 32'h0000_0001 << pos[20 + p]
                                         : 32'h0000_0000;
          rdchk("flags_low", OFS_FLAGS_LOW,
                {16'h0000, exp[15:0]});
          rdchk("flags_high", OFS_FLAGS_HIGH,
                {16'h0000, exp[31:16]});
          clear();
        end
      end
    end
    $display("test pin_edges done");
    wr(OFS_ENABLE_LOW, 32'h0000_0000);
    pulse(0);
    rdchk("pend_low", OFS_PEND_LOW, 32'h0000_0000);
    chk("request_any", 32'h0000_0000, {31'h0000_0000, request_any});
    wr(OFS_ENABLE_LOW, 32'h0000_FFFF);
    rdchk("pend_low", OFS_PEND_LOW, 32'h0000_8000);
    chk("pend_lo", 32'h0000_8000, {16'h0000, pend_lo});
    chk("request_any", 32'h0000_0001, {31'h0000_0000, request_any});
    // a one-cycle request that meets the clearing edge must survive it
    fork
      wr(OFS_FLAGS_LOW, 32'h0000_0000);
      begin
        @(posedge clk_sys);
        want <= 20'h0_0001;
        @(posedge clk_sys);
        want <= 20'h0_0000;
      end
    join
    rdchk("flags_low", OFS_FLAGS_LOW, 32'h0000_8000);
    clear();
    rdchk("flags_low", OFS_FLAGS_LOW, 32'h0000_0000);
    $display("test enable_and_hold done");
    apb(1'b1, OFS_PEND_LOW, 32'h0000_FFFF, 4'hF);
    chk("pend_write_err", 32'h0000_0001, {31'h0000_0000, rerr});
    rdchk("unmapped", 12'h01C, 32'h0000_0000);
    chk("unmapped_err", 32'h0000_0001, {31'h0000_0000, rerr});
    pulse(11);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rdchk("flags_high", OFS_FLAGS_HIGH, 32'h0000_0000);
    rdchk("enable_low", OFS_ENABLE_LOW, 32'h0000_0000);
    $display("test refusals_and_reset done");
    tally_and_finish();
  end
endmodule : ifsb_flag_bank_bench
`default_nettype wire
